// *** design/adsq_pkg.sv ***
// Purpose: constants for the converter sequencer control block
// Assumes: 32-bit ahb-lite register bus, one register per word
// Notes:   offsets are byte addresses
package adsq_pkg;
	localparam logic [7:0] ADSQ_CTRL_OFS   = 8'h00;
	localparam logic [7:0] ADSQ_RES0_OFS   = 8'h04;
	localparam logic [7:0] ADSQ_OPT_OFS    = 8'h14;
	localparam logic [7:0] ADSQ_STOP_OFS   = 8'h18;
	localparam int         ADSQ_DONE_BIT   = 7;
	localparam int         ADSQ_SCAN_BIT   = 5;
	localparam int         ADSQ_MULTI_CHANNEL_BIT   = 4;
	localparam int         ADSQ_PWR_BIT    = 7;
	localparam int         ADSQ_CONV_CLOCK_SOURCE_BIT   = 6;
	localparam int         ADSQ_DLY_BIT    = 4;
	localparam logic [7:0] ADSQ_OPT_RST    = 8'h10;
	localparam logic [7:0] ADSQ_OPT_ONCE   = 8'h10;
	localparam logic [7:0] ADSQ_OPT_MASK   = 8'hfb;
	localparam int         ADSQ_ONCE_CYC   = 64;
	localparam int         ADSQ_SAMPLE_CYC = 12;
	localparam int         ADSQ_CONV_CYC   = 32;
	localparam int         ADSQ_NBITS      = 8;
	localparam int         ADSQ_STOP_DLY   = 4000;
	localparam int         ADSQ_STOP_FAST  = 4;
	localparam logic [3:0] ADSQ_CH_REFHI   = 4'hc;
	localparam logic [3:0] ADSQ_CH_REFLO   = 4'hd;
	localparam logic [3:0] ADSQ_CH_HALF    = 4'he;
	typedef enum logic [3:0] {
		ADSQ_IDLE  = 4'b0001,
		ADSQ_SAMP  = 4'b0010,
		ADSQ_CONV  = 4'b0100,
		ADSQ_HOLD  = 4'b1000
	} adsq_state_t;
endpackage

// *** design/adsq_top.sv ***
// Purpose: sequencer control of an 8-bit successive approximation converter
// Assumes: ahb-lite slave, zero wait states, always OKAY
// Notes:   comp_i is the comparator decision on dac_o, same clock, read direct
//
// Contract
// - select one of 16 sources by chan_select
// - eight comparisons per conversion, msb first
// - copy approximation value to its result register
// - four readable 8-bit result registers
// - result updates never collide with reads
// - clock source select, E clock or rc
// - sequences of four, single or continuous
// - done flag after fourth conversion
// - analog_power_on enables converter
// - protected option bit 4 writes once in 64 cycles, any time in special mode
// - stop exit waits 4000 or four cycles
// - sequence starts one cycle after control write
// - ref_low gives 00, ref_high ff, no overflow
// - channel map, reserved and reference channels
// - single mode fills four results then halts
// - continuous mode overwrites results cyclically
// - input switch closes only for 12 cycles
// - control write clears flag, restarts sequence
// - multi mode converts group of four channels
// - single mode converts one channel four times
// - stop or wait suspends, resample on resume
`timescale 1ns/1ps
module adsq_top
	import adsq_pkg::*;
#(
	parameter int STOP_DLY_CYC = ADSQ_STOP_DLY
) (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	// ahb-lite slave
	input  wire logic        hsel_i,
	input  wire logic [7:0]  haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic        hready_i,
	input  wire logic [31:0] hwdata_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// system mode
	input  wire logic        special_mode_i,
	input  wire logic        low_power_i,
	output logic             cpu_run_o,
	// analog side
	input  wire logic        comp_i,
	output logic      [3:0]  mux_sel_o,
	output logic             sample_o,
	output logic      [7:0]  dac_o,
	output logic             analog_power_on_o,
	output logic             conv_clock_source_o
);
	////////////////////////////////////////////////////////////////////
	adsq_state_t st_q;
	logic        wr_ph_q;
	logic        rd_ph_q;
	logic [7:0]  addr_q;
	logic [5:0]  ctrl_q;
	logic        done_q;
	logic [7:0]  opt_q;
	logic        once_q;
	logic [6:0]  age_q;
	logic        start_q;
	logic [1:0]  idx_q;
	logic [4:0]  cyc_q;
	logic [7:0]  sar_q;
	logic [7:0]  res_q [4];
	logic [4:0]  samp_len_q;
	logic        lp_m_q;
	logic        lp_s_q;
	logic        lp_d_q;
	logic [12:0] stop_cnt_q;
	logic        ctrl_wr;
	logic        take;
	logic [2:0]  bitn;
	////////////////////////////////////////////////////////////////////
	// bus slave
	assign take        = hsel_i & hready_i & htrans_i[1];
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign ctrl_wr     = wr_ph_q & (addr_q == ADSQ_CTRL_OFS);

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			wr_ph_q <= 1'b0;
			rd_ph_q <= 1'b0;
			addr_q  <= 8'h00;
		end else begin
			wr_ph_q <= take & hwrite_i;
			rd_ph_q <= take & ~hwrite_i;
			addr_q  <= haddr_i;
		end
	end

	// read data from flip-flops, results sampled at address phase
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			hrdata_o <= 32'h0;
		end else if (take & ~hwrite_i) begin
			case (haddr_i)
				ADSQ_CTRL_OFS: hrdata_o <= {24'h0, done_q, 1'b0, ctrl_q};
				8'h04, 8'h08, 8'h0c, 8'h10: hrdata_o <=
					{24'h0, res_q[2'((haddr_i - ADSQ_RES0_OFS) >> 2)]};
				ADSQ_OPT_OFS:  hrdata_o <= {24'h0, opt_q & ADSQ_OPT_MASK};
				ADSQ_STOP_OFS: hrdata_o <= {31'h0, cpu_run_o};
				default:       hrdata_o <= 32'h0;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////
	// control register and done flag
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			ctrl_q  <= 6'h00;
			start_q <= 1'b0;
		end else begin
			start_q <= ctrl_wr;
			if (ctrl_wr) begin
				ctrl_q <= hwdata_i[5:0];
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			done_q <= 1'b0;
		end else if (ctrl_wr) begin
			done_q <= 1'b0;
		end else if (st_q == ADSQ_CONV && cyc_q == 5'(ADSQ_CONV_CYC - 1)
			&& idx_q == 2'd3 && cpu_run_o && analog_power_on_o
			&& !start_q) begin
			done_q <= 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////////
	// options register with write-once bit 4
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			opt_q  <= ADSQ_OPT_RST;
			once_q <= 1'b0;
			age_q  <= 7'h0;
		end else begin
			if (age_q != 7'(ADSQ_ONCE_CYC)) begin
				age_q <= age_q + 7'h1;
			end
			if (wr_ph_q && addr_q == ADSQ_OPT_OFS) begin
				opt_q <= (hwdata_i[7:0] & ~ADSQ_OPT_ONCE) |
					(opt_q & ADSQ_OPT_ONCE);
				if (special_mode_i ||
					(!once_q && age_q < 7'(ADSQ_ONCE_CYC))) begin
					opt_q[ADSQ_DLY_BIT] <= hwdata_i[ADSQ_DLY_BIT];
					once_q <= 1'b1;
				end
			end
		end
	end
	assign analog_power_on_o   = opt_q[ADSQ_PWR_BIT];
	assign conv_clock_source_o = opt_q[ADSQ_CONV_CLOCK_SOURCE_BIT];
	////////////////////////////////////////////////////////////////////
	// low power input sync and stop exit delay
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			lp_m_q   <= 1'b0;
			lp_s_q   <= 1'b0;
			lp_d_q   <= 1'b0;
		end else begin
			lp_m_q   <= low_power_i;
			lp_s_q   <= lp_m_q;
			lp_d_q   <= lp_s_q;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			stop_cnt_q <= 13'h0;
		end else if (lp_s_q) begin
			stop_cnt_q <= 13'h0;
		end else if (lp_d_q) begin
			stop_cnt_q <= opt_q[ADSQ_DLY_BIT] ? 13'(STOP_DLY_CYC) :
				13'(ADSQ_STOP_FAST);
		end else if (stop_cnt_q != 13'h0) begin
			stop_cnt_q <= stop_cnt_q - 13'h1;
		end
	end
	assign cpu_run_o = ~lp_s_q & ~lp_d_q & (stop_cnt_q == 13'h0);
	////////////////////////////////////////////////////////////////////
	// conversion sequencer
	assign bitn = 3'(ADSQ_CONV_CYC - 1 - 32'(cyc_q));
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			st_q  <= ADSQ_IDLE;
			idx_q <= 2'd0;
			cyc_q <= 5'd0;
			sar_q <= 8'h00;
		end else if (start_q) begin
			st_q  <= ADSQ_SAMP;
			idx_q <= 2'd0;
			cyc_q <= 5'd0;
			sar_q <= 8'h80;
		end else begin
			case (st_q)
				ADSQ_IDLE: begin
					cyc_q <= 5'd0;
				end
				ADSQ_SAMP: begin
					if (!cpu_run_o || !analog_power_on_o) begin
						st_q <= ADSQ_HOLD;
					end else begin
						cyc_q <= cyc_q + 5'd1;
						if (cyc_q == 5'(ADSQ_SAMPLE_CYC - 1)) begin
							st_q <= ADSQ_CONV;
						end
					end
				end
				ADSQ_CONV: begin
					if (!cpu_run_o || !analog_power_on_o) begin
						st_q <= ADSQ_HOLD;
					end else begin
						cyc_q <= cyc_q + 5'd1;
						if (cyc_q >= 5'(ADSQ_CONV_CYC - ADSQ_NBITS)) begin
							sar_q[bitn] <= comp_i;
							if (bitn != 3'd0) begin
								sar_q[bitn - 3'd1] <= 1'b1;
							end
						end
						if (cyc_q == 5'(ADSQ_CONV_CYC - 1)) begin
							idx_q <= idx_q + 2'd1;
							cyc_q <= 5'd0;
							sar_q <= 8'h80;
							st_q  <= (idx_q == 2'd3 && !ctrl_q[ADSQ_SCAN_BIT]) ?
								ADSQ_IDLE : ADSQ_SAMP;
						end
					end
				end
				ADSQ_HOLD: begin
					cyc_q <= 5'd0;
					sar_q <= 8'h80;
					if (cpu_run_o && analog_power_on_o) begin
						st_q <= ADSQ_SAMP;
					end
				end
				default: st_q <= ADSQ_IDLE;
			endcase
		end
	end

	// result storage; reads sample in address phase so no collision
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			for (int i = 0; i < 4; i++) begin
				res_q[i] <= 8'h00;
			end
		end else if (st_q == ADSQ_CONV && cpu_run_o && analog_power_on_o
			&& !start_q && cyc_q == 5'(ADSQ_CONV_CYC - 1)) begin
			res_q[idx_q] <= {sar_q[7:1], comp_i};
		end
	end

	// channel selection
	always_comb begin
		if (ctrl_q[ADSQ_MULTI_CHANNEL_BIT]) begin
			mux_sel_o = {ctrl_q[3:2], idx_q};
		end else begin
			mux_sel_o = ctrl_q[3:0];
		end
	end
	assign sample_o = (st_q == ADSQ_SAMP);
	assign dac_o    = sar_q;

	// sample window length, restarted by a new sequence
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || start_q || !sample_o) begin
			samp_len_q <= 5'd0;
		end else begin
			samp_len_q <= samp_len_q + 5'd1;
		end
	end
	////////////////////////////////////////////////////////////////////
	// checks
	property p_done_after_four;
		@(posedge ref_clk_i) disable iff (reset_i)
		(st_q == ADSQ_CONV && cyc_q == 5'd31 && idx_q == 2'd3 && cpu_run_o
			&& analog_power_on_o && !ctrl_wr && !start_q) |=> done_q;
	endproperty
	a_done_after_four: assert property (p_done_after_four)
		else $error("done flag not set after fourth conversion");

	property p_write_clears;
		@(posedge ref_clk_i) disable iff (reset_i)
		ctrl_wr |=> !done_q ##1 (st_q == ADSQ_SAMP && idx_q == 2'd0);
	endproperty
	a_write_clears: assert property (p_write_clears)
		else $error("control write did not restart sequence");

	property p_sample_len;
		@(posedge ref_clk_i) disable iff (reset_i)
		($fell(sample_o) && st_q == ADSQ_CONV)
			|-> samp_len_q == 5'(ADSQ_SAMPLE_CYC);
	endproperty
	a_sample_len: assert property (p_sample_len)
		else $error("sample window length wrong");

	property p_sample_max;
		@(posedge ref_clk_i) disable iff (reset_i)
		sample_o |-> samp_len_q < 5'(ADSQ_SAMPLE_CYC);
	endproperty
	a_sample_max: assert property (p_sample_max)
		else $error("sample window too long");

	property p_single_halts;
		@(posedge ref_clk_i) disable iff (reset_i)
		(st_q == ADSQ_CONV && cyc_q == 5'd31 && idx_q == 2'd3 && cpu_run_o
			&& analog_power_on_o && !start_q && !ctrl_q[5])
			|=> st_q == ADSQ_IDLE;
	endproperty
	a_single_halts: assert property (p_single_halts)
		else $error("single pass did not halt");

	property p_mux_multi;
		@(posedge ref_clk_i) disable iff (reset_i)
		ctrl_q[4] |-> mux_sel_o == {ctrl_q[3:2], idx_q};
	endproperty
	a_mux_multi: assert property (p_mux_multi)
		else $error("group channel wrong");

	property p_stop_fast;
		@(posedge ref_clk_i) disable iff (reset_i)
		($fell(lp_s_q) && !opt_q[4]) |-> ##[1:6] cpu_run_o;
	endproperty
	a_stop_fast: assert property (p_stop_fast)
		else $error("fast stop exit too slow");

	property p_result_copy;
		@(posedge ref_clk_i) disable iff (reset_i)
		(st_q == ADSQ_CONV && cyc_q == 5'd31 && cpu_run_o
			&& analog_power_on_o && !start_q)
			|=> res_q[$past(idx_q)] == $past({sar_q[7:1], comp_i});
	endproperty
	a_result_copy: assert property (p_result_copy)
		else $error("result not copied");

	property p_start_delay;
		@(posedge ref_clk_i) disable iff (reset_i)
		ctrl_wr |=> start_q;
	endproperty
	a_start_delay: assert property (p_start_delay)
		else $error("start not one cycle after write");
endmodule

// *** bench/adsq_analog_model.sv ***
// Purpose: analog side, input levels and comparator
// Assumes: comp high while held input at or above trial
// Notes:   bench may change the level table
`timescale 1ns/1ps
module adsq_analog_model (
	// converter side
	input  wire logic       ref_clk_i,
	input  wire logic [3:0] mux_sel_i,
	input  wire logic       sample_i,
	input  wire logic [7:0] dac_i,
	output logic            comp_o
);
	logic [7:0] level [16];
	logic [7:0] held_q = 8'h00;
	initial begin
		for (int i = 0; i < 16; i++) level[i] = 8'(i * 31 + 5);
		level[12] = 8'hff;
		level[13] = 8'h00;
		level[14] = 8'h80;
	end
	// tracks the level only while the switch is closed, held otherwise
	always @(posedge ref_clk_i) begin
		if (sample_i) held_q <= level[mux_sel_i];
	end
	assign comp_o = (held_q >= dac_i);
endmodule

// *** bench/adsq_top_test.sv ***
// Purpose: register level bench for adsq_top
// Assumes: analog model on the comparator side
// Notes:   stop delay shortened to 20 cycles
`timescale 1ns/1ps
`define CHK(s, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] %s exp %h got %h", s, e, g); end end
module adsq_top_test;
	import adsq_pkg::*;
	logic        ref_clk_i = 0, reset_i = 1, hsel_i = 0, hwrite_i = 0;
	logic        special_mode_i = 0, low_power_i = 0;
	logic [7:0]  haddr_i = 8'h00;
	logic [1:0]  htrans_i = 2'h0;
	logic [2:0]  hsize_i = 3'h0;
	logic [31:0] hwdata_i = 32'h0, hrdata_o, rd;
	logic        hreadyout_o, hresp_o, cpu_run_o, comp_i, sample_o;
	logic        analog_power_on_o, conv_clock_source_o;
	logic [3:0]  mux_sel_o;
	logic [7:0]  dac_o;
	int          n_fail = 0, check_count = 0, cyc = 0, scnt = 0, n, t;
	always #12.5 ref_clk_i = ~ref_clk_i;
	adsq_top #(.STOP_DLY_CYC(20)) i_adsq_top (.ref_clk_i, .reset_i, .hsel_i,
		.haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hready_i(hreadyout_o),
		.hwdata_i, .hrdata_o, .hreadyout_o, .hresp_o, .special_mode_i,
		.low_power_i, .cpu_run_o, .comp_i, .mux_sel_o, .sample_o, .dac_o,
		.analog_power_on_o, .conv_clock_source_o);
	adsq_analog_model i_adsq_analog_model (.ref_clk_i, .mux_sel_i(mux_sel_o),
		.sample_i(sample_o), .dac_i(dac_o), .comp_o(comp_i));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lv(input int ch);
		return {24'h0, i_adsq_analog_model.level[ch]};
	endfunction
	task automatic results;
		if (n_fail == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		hsel_i <= 1'b1;
		htrans_i <= 2'b10;
		haddr_i <= a;
		hwrite_i <= w;
		hsize_i <= 3'b010;
		do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'b00;
		hwdata_i <= d;
		do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
		rd = hrdata_o;
	endtask
	task automatic chk_rd(input string s, input logic [7:0] a,
		input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		`CHK(s, e, rd)
		`CHK("resp", 1'b0, hresp_o)
	endtask
	task automatic wait_done(input int lim);
		n = 0;
		do begin
			ahb(1'b0, ADSQ_CTRL_OFS, 32'h0);
			n++;
		end while (rd[ADSQ_DONE_BIT] !== 1'b1 && n < lim);
		`CHK("done_flag", 1'b1, rd[ADSQ_DONE_BIT])
	endtask
	task automatic chk_res(input int c0, input int step);
		for (int i = 0; i < 4; i++) begin
			chk_rd("result", ADSQ_RES0_OFS + 8'(4 * i), lv(c0 + step * i));
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
		if (sample_o === 1'b1) scnt <= scnt + 1;
		else begin
			if (scnt != 0) `CHK("sample_len", 12, scnt)
			scnt <= 0;
		end
	end
	initial begin
		repeat (20) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		chk_rd("opt_rst", ADSQ_OPT_OFS, {24'h0, ADSQ_OPT_RST});
		chk_rd("ctrl_rst", ADSQ_CTRL_OFS, 32'h0);
		ahb(1'b1, ADSQ_OPT_OFS, 32'h90);
		chk_rd("opt_pwr", ADSQ_OPT_OFS, 32'h90);
		`CHK("pwr_pin", 1'b1, analog_power_on_o)
		repeat (4000) @(posedge ref_clk_i);
		// single channel, four results
		ahb(1'b1, ADSQ_CTRL_OFS, 32'h03);
		t = cyc;
		wait_done(100);
		`CHK("seq_len", 1'b1, (cyc - t >= 128 && cyc - t <= 140))
		chk_res(3, 0);
		// multi channel groups, references included
		ahb(1'b1, ADSQ_CTRL_OFS, 32'h14);
		wait_done(100);
		chk_res(4, 1);
		ahb(1'b1, ADSQ_CTRL_OFS, 32'h1c);
		wait_done(100);
		for (int i = 0; i < 3; i++) chk_rd("ref", ADSQ_RES0_OFS + 8'(4 * i), lv(12 + i));
		// restart in mid-sequence
		ahb(1'b1, ADSQ_CTRL_OFS, 32'h05);
		chk_rd("ctrl_clr0", ADSQ_CTRL_OFS, 32'h05);
		repeat (20) @(posedge ref_clk_i);
		ahb(1'b1, ADSQ_CTRL_OFS, 32'h06);
		chk_rd("ctrl_clr", ADSQ_CTRL_OFS, 32'h06);
		wait_done(100);
		chk_res(6, 0);
		// stop in mid-sequence, delayed exit
		ahb(1'b1, ADSQ_CTRL_OFS, 32'h01);
		repeat (50) @(posedge ref_clk_i);
		low_power_i <= 1'b1;
		repeat (10) @(posedge ref_clk_i);
		`CHK("run_stop", 1'b0, cpu_run_o)
		low_power_i <= 1'b0;
		for (n = 0; n < 100 && cpu_run_o !== 1'b1; n++) @(posedge ref_clk_i);
		`CHK("dly_exit", 1'b1, (n >= 20 && n <= 28))
		wait_done(200);
		chk_res(1, 0);
		// protected bit, normal then special mode
		ahb(1'b1, ADSQ_OPT_OFS, 32'h80);
		chk_rd("opt_once", ADSQ_OPT_OFS, 32'h90);
		special_mode_i <= 1'b1;
		ahb(1'b1, ADSQ_OPT_OFS, 32'hc4);
		chk_rd("opt_spec", ADSQ_OPT_OFS, 32'hc0);
		`CHK("clk_src", 1'b1, conv_clock_source_o)
		low_power_i <= 1'b1;
		repeat (10) @(posedge ref_clk_i);
		low_power_i <= 1'b0;
		for (n = 0; n < 100 && cpu_run_o !== 1'b1; n++) @(posedge ref_clk_i);
		`CHK("fast_exit", 1'b1, (n <= 8))
		// continuous scan overwrites
		ahb(1'b1, ADSQ_CTRL_OFS, 32'h22);
		wait_done(100);
		i_adsq_analog_model.level[2] = 8'h3c;
		repeat (300) @(posedge ref_clk_i);
		chk_res(2, 0);
		chk_rd("unmapped", 8'h40, 32'h0);
		results();
	end
endmodule
